// File: hw/dct_pkg.sv
// Shared constants, access carrier and byte helpers for the time-loop block.
// Assumes byte-wide register access from both the network side and the host side.
package dct_pkg;
  // Register byte offsets
  localparam logic [15:0] OFS_RX_P0 = 16'h0900;
  localparam logic [15:0] OFS_RX_P1 = 16'h0904;
  localparam logic [15:0] OFS_SYS_TIME = 16'h0910;
  localparam logic [15:0] OFS_SYS_TIME_TOP = 16'h0913;
  localparam logic [15:0] OFS_RX_PU = 16'h0918;
  localparam logic [15:0] OFS_SYS_OFFSET = 16'h0920;
  localparam logic [15:0] OFS_SYS_DELAY = 16'h0928;
  localparam logic [15:0] OFS_SYS_DIFF = 16'h092C;
  // Register lengths in bytes
  localparam logic [15:0] LEN_W32 = 16'h0004;
  localparam logic [15:0] LEN_W64 = 16'h0008;
  // Values after reset
  localparam logic [63:0] TIME_RST = 64'h0000_0000_0000_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Default distributed-clock width and difference filter depth
  localparam int DC_WIDTH_DEF = 64;
  localparam int FILT_DEPTH_DEF = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dct_acc_s;

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] base,
                               input logic [15:0] len);
    hit = (addr >= base) && (addr < 16'(base + len));
  endfunction : hit

  function automatic logic [7:0] get_byte(input logic [63:0] v, input logic [2:0] i);
    get_byte = v[{i, 3'b000} +: 8];
  endfunction : get_byte

  function automatic logic [63:0] put_byte(input logic [63:0] v, input logic [2:0] i,
                                           input logic [7:0] b);
    logic [63:0] r;
    r = v;
    r[{i, 3'b000} +: 8] = b;
    put_byte = r;
  endfunction : put_byte
endpackage : dct_pkg

// File: hw/dct_timebase.sv
// Free-running local time and the local copy of system time.
// Assumes offset and delay come from registers in the same clock domain.
`timescale 1ns/1ns
module dct_timebase
  import dct_pkg::*;
#(
  parameter int DC_W = DC_WIDTH_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Correction terms
  input wire logic [63:0] offset_i,
  input wire logic [31:0] delay_i,
  // Time outputs
  output logic [63:0] local_time_o,
  output logic [63:0] sys_time_o
);
  if (DC_W != 32 && DC_W != 64) begin : g_bad_width
    $error("DC_W must be 32 or 64");
  end

  logic [63:0] local_cnt;
  logic [63:0] sys_cnt;
  logic [63:0] next_local_cnt;
  logic [63:0] next_sys_cnt;
  logic [63:0] width_mask;

  always_comb begin
    width_mask = (DC_W == 64) ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
    next_local_cnt = (local_cnt + 64'h1) & width_mask;
    next_sys_cnt = (next_local_cnt + offset_i + {32'h0, delay_i}) & width_mask;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      local_cnt <= TIME_RST;
      sys_cnt <= TIME_RST;
    end else begin
      local_cnt <= next_local_cnt;
      sys_cnt <= next_sys_cnt;
    end
  end

  assign local_time_o = local_cnt;
  assign sys_time_o = sys_cnt;
endmodule : dct_timebase

// File: hw/dct_diff_filter.sv
// Averaging filter of the system-time deviation, sign-magnitude result.
// Assumes one compare strobe at a time with both time values valid.
`timescale 1ns/1ns
module dct_diff_filter
  import dct_pkg::*;
#(
  parameter int DEPTH = FILT_DEPTH_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Compare request
  input wire logic sample_i,
  input wire logic [31:0] local_i,
  input wire logic [31:0] recv_i,
  // Filtered result
  output logic [31:0] diff_o
);
  if (DEPTH < 0 || DEPTH > 15) begin : g_bad_depth
    $error("DEPTH must be 0..15");
  end

  logic signed [31:0] mean;
  logic signed [31:0] next_mean;
  logic [31:0] diff;
  logic [31:0] next_diff;
  logic signed [31:0] delta;

  always_comb begin
    delta = $signed(local_i - recv_i);
    next_mean = mean;
    if (sample_i) begin
      next_mean = mean + ((delta - mean) >>> DEPTH);
    end
    // Bit 31 set when local copy is behind the received time
    if (next_mean < 0) begin
      next_diff = {1'b1, 31'(-next_mean)};
    end else begin
      next_diff = {1'b0, next_mean[30:0]};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mean <= WORD_RST;
      diff <= WORD_RST;
    end else begin
      mean <= next_mean;
      diff <= next_diff;
    end
  end

  assign diff_o = diff;
endmodule : dct_diff_filter

// File: hw/dct_receive_time_loop.sv
// Receive time stamps and system-time control loop of a fieldbus slave controller.
// Assumes frame strobes and byte accesses are single-cycle and synchronous to SYS_CLK_I.
// Summary of operation
// - Broadcast or configured write to port-0 receive time captures frame starts.
// - Port-0 receive time reads the start of the last capturing frame.
// - Port-1 receive time holds port-1 frame start of capturing frame.
// - Time base is 32 or 64 bits wide by variant; port-0 and port-1 stamps are 32 bits.
// - Network read of system time returns copy latched at start delimiter.
// - Host read snapshots system time on lowest byte for consistent bytes.
// - Network write with low byte compares at frame end against latched copy.
// - Host write with top low-word byte compares against latch-zero edge time.
// - Loop registers are network-writable unless host-controlled time is configured.
// - Processing-unit receive time holds its 64-bit frame start time.
// - Local system time is local time plus offset register plus delay register.
// - Writable 32-bit delay register forms part of the system-time copy.
// - Difference register gives filtered magnitude and sign bit.
`timescale 1ns/1ns
module dct_receive_time_loop
  import dct_pkg::*;
#(
  parameter int DC_W = DC_WIDTH_DEF,
  parameter int FILT_DEPTH = FILT_DEPTH_DEF
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  // Frame timing from the ports
  input wire logic NET_P0_START_I,
  input wire logic NET_P1_START_I,
  input wire logic NET_PU_START_I,
  input wire logic NET_SOF_I,
  input wire logic NET_FRAME_END_I,
  // Network-side register access
  input wire dct_acc_s NET_ACC_I,
  input wire logic NET_BWR_FPWR_I,
  output logic [7:0] NET_RDATA_O,
  // Host-side register access
  input wire dct_acc_s HOST_ACC_I,
  input wire logic HOST_ACC_END_I,
  output logic [7:0] HOST_RDATA_O,
  // Configuration and latch unit
  input wire logic HOST_TIME_CTRL_I,
  input wire logic [31:0] LATCH_UNIT_ZERO_POS_TIME_I,
  // Status
  output logic [63:0] SYS_TIME_O,
  output logic [31:0] SYS_DIFF_O
);
  if (DC_W != 32 && DC_W != 64) begin : g_bad_width
    $error("DC_W must be 32 or 64");
  end

  logic [63:0] local_time;
  logic [63:0] sys_time;
  logic [31:0] sys_diff;

  // Stamps of the current frame, published at its end
  logic [63:0] stg_p0;
  logic [63:0] stg_p1;
  logic [63:0] stg_pu;
  logic pend_rx;
  logic [31:0] rx_p0;
  logic [31:0] rx_p1;
  logic [63:0] rx_pu;
  logic [63:0] sof_copy;
  logic [31:0] net_wbuf;
  logic net_wlow;
  logic [31:0] host_wbuf;
  logic host_wtop;
  logic [63:0] host_snap;
  logic [63:0] sys_offset;
  logic [31:0] sys_delay;
  logic [7:0] net_rdata;
  logic [7:0] host_rdata;

  logic [63:0] next_stg_p0;
  logic [63:0] next_stg_p1;
  logic [63:0] next_stg_pu;
  logic next_pend_rx;
  logic [31:0] next_rx_p0;
  logic [31:0] next_rx_p1;
  logic [63:0] next_rx_pu;
  logic [63:0] next_sof_copy;
  logic [31:0] next_net_wbuf;
  logic next_net_wlow;
  logic [31:0] next_host_wbuf;
  logic next_host_wtop;
  logic [63:0] next_host_snap;
  logic [63:0] next_sys_offset;
  logic [31:0] next_sys_delay;
  logic [7:0] next_net_rdata;
  logic [7:0] next_host_rdata;

  logic net_cfg_wr;
  logic host_cfg_wr;
  logic net_cmp;
  logic host_cmp;
  logic cmp_valid;
  logic [31:0] cmp_local;
  logic [31:0] cmp_recv;
  logic [2:0] net_idx;
  logic [2:0] host_idx;

  dct_timebase #(
    .DC_W(DC_W)
  ) u_timebase (
    .clk_i(SYS_CLK_I),
    .nrst_i(NRST_I),
    .offset_i(sys_offset),
    .delay_i(sys_delay),
    .local_time_o(local_time),
    .sys_time_o(sys_time)
  );

  dct_diff_filter #(
    .DEPTH(FILT_DEPTH)
  ) u_diff_filter (
    .clk_i(SYS_CLK_I),
    .nrst_i(NRST_I),
    .sample_i(cmp_valid),
    .local_i(cmp_local),
    .recv_i(cmp_recv),
    .diff_o(sys_diff)
  );

  // Compare source selection
  always_comb begin
    net_cmp = NET_FRAME_END_I && net_wlow && !HOST_TIME_CTRL_I;
    host_cmp = HOST_ACC_END_I && host_wtop && HOST_TIME_CTRL_I;
    cmp_valid = net_cmp || host_cmp;
    cmp_local = net_cmp ? sof_copy[31:0] : LATCH_UNIT_ZERO_POS_TIME_I;
    cmp_recv = net_cmp ? net_wbuf : host_wbuf;
  end

  // Read-back multiplexers
  function automatic logic [7:0] rd_byte(input logic [15:0] a, input logic [63:0] sys_v,
                                         input logic [31:0] p0, input logic [31:0] p1,
                                         input logic [63:0] pu, input logic [63:0] ofs,
                                         input logic [31:0] dly, input logic [31:0] dif);
    logic [7:0] r;
    r = BYTE_RST;
    if (hit(a, OFS_RX_P0, LEN_W32)) begin
      r = get_byte({32'h0, p0}, {1'b0, a[1:0]});
    end else if (hit(a, OFS_RX_P1, LEN_W32)) begin
      r = get_byte({32'h0, p1}, {1'b0, a[1:0]});
    end else if (hit(a, OFS_SYS_TIME, LEN_W64)) begin
      r = get_byte(sys_v, a[2:0]);
    end else if (hit(a, OFS_RX_PU, LEN_W64)) begin
      r = get_byte(pu, a[2:0]);
    end else if (hit(a, OFS_SYS_OFFSET, LEN_W64)) begin
      r = get_byte(ofs, a[2:0]);
    end else if (hit(a, OFS_SYS_DELAY, LEN_W32)) begin
      r = get_byte({32'h0, dly}, {1'b0, a[1:0]});
    end else if (hit(a, OFS_SYS_DIFF, LEN_W32)) begin
      r = get_byte({32'h0, dif}, {1'b0, a[1:0]});
    end
    rd_byte = r;
  endfunction : rd_byte

  always_comb begin
    net_cfg_wr = NET_ACC_I.wr && !HOST_TIME_CTRL_I;
    host_cfg_wr = HOST_ACC_I.wr && HOST_TIME_CTRL_I;
    net_idx = NET_ACC_I.addr[2:0];
    host_idx = HOST_ACC_I.addr[2:0];

    next_stg_p0 = stg_p0;
    next_stg_p1 = stg_p1;
    next_stg_pu = stg_pu;
    next_pend_rx = pend_rx;
    next_rx_p0 = rx_p0;
    next_rx_p1 = rx_p1;
    next_rx_pu = rx_pu;
    next_sof_copy = sof_copy;
    next_net_wbuf = net_wbuf;
    next_net_wlow = net_wlow;
    next_host_wbuf = host_wbuf;
    next_host_wtop = host_wtop;
    next_host_snap = host_snap;
    next_sys_offset = sys_offset;
    next_sys_delay = sys_delay;
    next_net_rdata = net_rdata;
    next_host_rdata = host_rdata;

    // Frame start stamps at each port and at the processing unit
    if (NET_P0_START_I) begin
      next_stg_p0 = local_time;
    end
    if (NET_P1_START_I) begin
      next_stg_p1 = local_time;
    end
    if (NET_PU_START_I) begin
      next_stg_pu = local_time;
    end
    if (NET_SOF_I) begin
      next_sof_copy = sys_time;
    end

    // Network writes; read-only registers are not decoded for writing
    if (NET_ACC_I.wr && NET_BWR_FPWR_I && NET_ACC_I.addr == OFS_RX_P0) begin
      next_pend_rx = 1'b1;
    end
    if (net_cfg_wr && hit(NET_ACC_I.addr, OFS_SYS_TIME, LEN_W32)) begin
      next_net_wbuf = 32'(put_byte({32'h0, net_wbuf}, {1'b0, net_idx[1:0]},
                                   NET_ACC_I.wdata));
      if (NET_ACC_I.addr == OFS_SYS_TIME) begin
        next_net_wlow = 1'b1;
      end
    end
    if (net_cfg_wr && hit(NET_ACC_I.addr, OFS_SYS_OFFSET, LEN_W64)) begin
      next_sys_offset = put_byte(sys_offset, net_idx, NET_ACC_I.wdata);
    end
    if (net_cfg_wr && hit(NET_ACC_I.addr, OFS_SYS_DELAY, LEN_W32)) begin
      next_sys_delay = 32'(put_byte({32'h0, sys_delay}, {1'b0, net_idx[1:0]},
                                    NET_ACC_I.wdata));
    end

    // Publish stamps only once the frame is over
    if (NET_FRAME_END_I) begin
      if (pend_rx || next_pend_rx) begin
        next_rx_p0 = stg_p0[31:0];
        next_rx_p1 = stg_p1[31:0];
        next_rx_pu = stg_pu;
      end
      next_pend_rx = 1'b0;
      next_net_wlow = 1'b0;
    end

    // Host writes
    if (host_cfg_wr && hit(HOST_ACC_I.addr, OFS_SYS_TIME, LEN_W32)) begin
      next_host_wbuf = 32'(put_byte({32'h0, host_wbuf}, {1'b0, host_idx[1:0]},
                                    HOST_ACC_I.wdata));
      if (HOST_ACC_I.addr == OFS_SYS_TIME_TOP) begin
        next_host_wtop = 1'b1;
      end
    end
    if (host_cfg_wr && hit(HOST_ACC_I.addr, OFS_SYS_OFFSET, LEN_W64)) begin
      next_sys_offset = put_byte(sys_offset, host_idx, HOST_ACC_I.wdata);
    end
    if (host_cfg_wr && hit(HOST_ACC_I.addr, OFS_SYS_DELAY, LEN_W32)) begin
      next_sys_delay = 32'(put_byte({32'h0, sys_delay}, {1'b0, host_idx[1:0]},
                                    HOST_ACC_I.wdata));
    end
    if (HOST_ACC_END_I) begin
      next_host_wtop = 1'b0;
    end

    // Read data, registered one cycle after the read strobe
    if (NET_ACC_I.rd) begin
      next_net_rdata = rd_byte(NET_ACC_I.addr, sof_copy, rx_p0, rx_p1, rx_pu,
                               sys_offset, sys_delay, sys_diff);
    end
    if (HOST_ACC_I.rd) begin
      if (HOST_ACC_I.addr == OFS_SYS_TIME) begin
        next_host_snap = sys_time;
        next_host_rdata = get_byte(sys_time, 3'h0);
      end else begin
        next_host_rdata = rd_byte(HOST_ACC_I.addr, host_snap, rx_p0, rx_p1, rx_pu,
                                  sys_offset, sys_delay, sys_diff);
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      stg_p0 <= TIME_RST;
      stg_p1 <= TIME_RST;
      stg_pu <= TIME_RST;
      pend_rx <= 1'b0;
      rx_p0 <= WORD_RST;
      rx_p1 <= WORD_RST;
      rx_pu <= TIME_RST;
      sof_copy <= TIME_RST;
      net_wbuf <= WORD_RST;
      net_wlow <= 1'b0;
      host_wbuf <= WORD_RST;
      host_wtop <= 1'b0;
      host_snap <= TIME_RST;
      sys_offset <= TIME_RST;
      sys_delay <= WORD_RST;
      net_rdata <= BYTE_RST;
      host_rdata <= BYTE_RST;
    end else begin
      stg_p0 <= next_stg_p0;
      stg_p1 <= next_stg_p1;
      stg_pu <= next_stg_pu;
      pend_rx <= next_pend_rx;
      rx_p0 <= next_rx_p0;
      rx_p1 <= next_rx_p1;
      rx_pu <= next_rx_pu;
      sof_copy <= next_sof_copy;
      net_wbuf <= next_net_wbuf;
      net_wlow <= next_net_wlow;
      host_wbuf <= next_host_wbuf;
      host_wtop <= next_host_wtop;
      host_snap <= next_host_snap;
      sys_offset <= next_sys_offset;
      sys_delay <= next_sys_delay;
      net_rdata <= next_net_rdata;
      host_rdata <= next_host_rdata;
    end
  end

  assign NET_RDATA_O = net_rdata;
  assign HOST_RDATA_O = host_rdata;
  assign SYS_TIME_O = sys_time;
  assign SYS_DIFF_O = sys_diff;
endmodule : dct_receive_time_loop

// File: tb/dct_net_frames.sv
// Partner model: frame timing of the network master at the port side.
// Assumes go_i is a one-cycle pulse from the bench while no frame is running.
`timescale 1ns/1ns
module dct_net_frames (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Frame request
  input wire logic go_i,
  // Frame timing
  output logic p0_o,
  output logic p1_o,
  output logic pu_o,
  output logic sof_o,
  output logic end_o,
  output logic busy_o
);
  logic [3:0] ph;
  logic [3:0] next_ph;
  always_comb begin
    next_ph = ph;
    if (go_i) begin
      next_ph = 4'h1;
    end else if (ph == 4'hC) begin
      next_ph = 4'h0;
    end else if (ph != 4'h0) begin
      next_ph = ph + 4'h1;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph <= 4'h0;
    end else begin
      ph <= next_ph;
    end
  end
  assign p0_o = (ph == 4'h1);
  assign pu_o = (ph == 4'h1);
  assign p1_o = (ph == 4'h2);
  assign sof_o = (ph == 4'h3);
  // Frame ends late; stamps are only read back after it, never inside it
  assign end_o = (ph == 4'hC);
  assign busy_o = (ph != 4'h0);
endmodule : dct_net_frames

// File: tb/dct_receive_time_loop_props.sv
// Checker of the time-loop block, watching only the top module ports.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/1ns
module dct_receive_time_loop_props
  import dct_pkg::*;
#(
  parameter int DC_W = DC_WIDTH_DEF,
  parameter int FILT_DEPTH = FILT_DEPTH_DEF
) (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic NET_FRAME_END_I,
  input wire dct_acc_s NET_ACC_I,
  input wire logic [7:0] NET_RDATA_O,
  input wire dct_acc_s HOST_ACC_I,
  input wire logic HOST_ACC_END_I,
  input wire logic [7:0] HOST_RDATA_O,
  input wire logic HOST_TIME_CTRL_I,
  input wire logic [63:0] SYS_TIME_O,
  input wire logic [31:0] SYS_DIFF_O
);
  logic [31:0] diff_q;
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      diff_q <= WORD_RST;
    end else begin
      diff_q <= SYS_DIFF_O;
    end
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_no_wr;
    !NET_ACC_I.wr && !HOST_ACC_I.wr;
  endsequence
  sequence s_no_end;
    !NET_FRAME_END_I && !HOST_ACC_END_I;
  endsequence
  AST_TIME_RUNS: assert property (s_no_wr [*3] |=>
    SYS_TIME_O == $past(SYS_TIME_O) + 64'h1) else $error("system time not advancing");
  AST_HOST_WR_IGNORED: assert property ((!NET_ACC_I.wr && !HOST_TIME_CTRL_I) [*3] |=>
    SYS_TIME_O == $past(SYS_TIME_O) + 64'h1) else $error("host write moved system time");
  AST_DIFF_HOLDS: assert property (s_no_end [*3] |=> $stable(SYS_DIFF_O))
    else $error("difference changed without compare");
  AST_DIFF_SIGN: assert property (SYS_DIFF_O[31] |-> SYS_DIFF_O[30:0] != 31'h0)
    else $error("negative difference with zero magnitude");
  AST_NET_DIFF_RD: assert property (NET_ACC_I.rd && NET_ACC_I.addr == OFS_SYS_DIFF
    |=> NET_RDATA_O == diff_q[7:0]) else $error("network difference byte wrong");
  AST_HOST_DIFF_RD: assert property (HOST_ACC_I.rd && HOST_ACC_I.addr == 16'h092D
    |=> HOST_RDATA_O == diff_q[15:8]) else $error("host difference byte wrong");
  AST_NET_UNMAPPED: assert property (NET_ACC_I.rd && NET_ACC_I.addr == 16'h0950
    |=> NET_RDATA_O == 8'h00) else $error("unmapped read not zero");
  AST_NET_RD_STANDS: assert property (!NET_ACC_I.rd |=> $stable(NET_RDATA_O))
    else $error("network read data moved");
  AST_HOST_RD_STANDS: assert property (!HOST_ACC_I.rd |=> $stable(HOST_RDATA_O))
    else $error("host read data moved");
endmodule : dct_receive_time_loop_props
bind dct_receive_time_loop dct_receive_time_loop_props #(.DC_W(DC_W), .FILT_DEPTH(FILT_DEPTH))
  u_dct_receive_time_loop_props (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I),
  .NET_FRAME_END_I(NET_FRAME_END_I), .NET_ACC_I(NET_ACC_I), .NET_RDATA_O(NET_RDATA_O),
  .HOST_ACC_I(HOST_ACC_I), .HOST_ACC_END_I(HOST_ACC_END_I), .HOST_RDATA_O(HOST_RDATA_O),
  .HOST_TIME_CTRL_I(HOST_TIME_CTRL_I), .SYS_TIME_O(SYS_TIME_O), .SYS_DIFF_O(SYS_DIFF_O));

// File: tb/dct_receive_time_loop_bench.sv
// Self-checking bench of the time-loop block with a frame-timing partner.
// Assumes one-byte register accesses and the default filter depth.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin fails++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module dct_receive_time_loop_bench
  import dct_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0, bwr = 1'b0, hend = 1'b0, hctrl = 1'b0, pn = 1'b0, ph = 1'b0;
  logic p0, p1, pu, sof, fend, busy;
  logic [31:0] latch = 32'h0, dly, lval;
  dct_acc_s n_acc = '0, h_acc = '0;
  logic [7:0] nrd, hrd, e;
  logic [63:0] stime, ofs, t0, lt, ts;
  logic [31:0] sdiff;
  logic [7:0] eq[$];
  int fails = 0, n_checks = 0, cyc = 0, seed = 32'h2B470BC5;
  always #20 clk = ~clk;
  always @(posedge clk or negedge nrst) lt <= !nrst ? 64'h0 : lt + 64'h1;
  dct_net_frames u_dct_net_frames (.clk_i(clk), .nrst_i(nrst), .go_i(go), .p0_o(p0),
    .p1_o(p1), .pu_o(pu), .sof_o(sof), .end_o(fend), .busy_o(busy));
  dct_receive_time_loop u_dct_receive_time_loop (.SYS_CLK_I(clk), .NRST_I(nrst),
    .NET_P0_START_I(p0), .NET_P1_START_I(p1), .NET_PU_START_I(pu), .NET_SOF_I(sof),
    .NET_FRAME_END_I(fend), .NET_ACC_I(n_acc), .NET_BWR_FPWR_I(bwr), .NET_RDATA_O(nrd),
    .HOST_ACC_I(h_acc), .HOST_ACC_END_I(hend), .HOST_RDATA_O(hrd),
    .HOST_TIME_CTRL_I(hctrl), .LATCH_UNIT_ZERO_POS_TIME_I(latch), .SYS_TIME_O(stime),
    .SYS_DIFF_O(sdiff));
  task automatic give_verdict();
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Read data is checked one cycle after the request was sampled
  always @(posedge clk) begin
    #2;
    if (pn || ph) begin
      e = eq.pop_front();
      `CHK("rdata", e, (pn ? nrd : hrd))
    end
    pn = n_acc.rd;
    ph = h_acc.rd;
    cyc++;
    if (cyc > 5000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic acc(input bit h, input logic w, input logic r, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    n_acc <= h ? '0 : dct_acc_s'{w, r, a, d};
    h_acc <= h ? dct_acc_s'{w, r, a, d} : '0;
  endtask : acc
  task automatic idl();
    acc(1'b0, 1'b0, 1'b0, 16'h0, 8'h0);
  endtask : idl
  task automatic wrn(input bit h, input logic [15:0] a, input int n, input logic [63:0] v);
    for (int i = 0; i < n; i++) acc(h, 1'b1, 1'b0, a + 16'(i), v[8*i +: 8]);
    idl();
  endtask : wrn
  task automatic rdn(input bit h, input logic [15:0] a, input int n, input logic [63:0] v);
    for (int i = 0; i < n; i++) begin
      acc(h, 1'b0, 1'b1, a + 16'(i), 8'h0);
      eq.push_back(v[8*i +: 8]);
    end
    idl();
  endtask : rdn
  task automatic frame_go(input logic b);
    @(posedge clk);
    go <= 1'b1;
    bwr <= b;
    #1 t0 = lt;
    @(posedge clk);
    go <= 1'b0;
  endtask : frame_go
  task automatic frame_end();
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk) #1;
    // A frame that never ends is a failure
    if (busy !== 1'b0) fails++;
    @(posedge clk);
    bwr <= 1'b0;
  endtask : frame_end
  initial begin
    ofs = {$random(seed), $random(seed)};
    dly = $random(seed);
    lval = $random(seed);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rdn(0, OFS_RX_P0, 4, 64'h0);
    rdn(0, OFS_SYS_DIFF, 4, 64'h0);
    rdn(0, 16'h0950, 1, 64'h0);
    wrn(0, OFS_SYS_OFFSET, 8, ofs);
    wrn(0, OFS_SYS_DELAY, 4, {32'h0, dly});
    wrn(1, OFS_SYS_OFFSET, 2, 64'h5A5A);
    rdn(1, OFS_SYS_OFFSET, 8, ofs);
    rdn(0, OFS_SYS_DELAY, 4, {32'h0, dly});
    // Frame without the broadcast flag, plus writes to the port-0 stamp and the difference register
    frame_go(1'b0);
    acc(0, 1'b1, 1'b0, OFS_RX_P0, 8'h11);
    wrn(0, OFS_SYS_DIFF, 2, 64'hFFFF);
    frame_end();
    rdn(0, OFS_RX_P0, 4, 64'h0);
    rdn(0, OFS_SYS_DIFF, 4, 64'h0);
    // Capturing frame with a system-time compare 32 below the copy
    frame_go(1'b1);
    acc(0, 1'b1, 1'b0, OFS_RX_P0, 8'h00);
    wrn(0, OFS_SYS_TIME, 4, {32'h0, 32'(t0 + 64'h3 + ofs + dly) - 32'h20});
    wrn(0, OFS_RX_P1, 1, 64'hAB);
    frame_end();
    rdn(0, OFS_RX_P0, 4, t0 + 64'h1);
    rdn(1, OFS_RX_P1, 4, t0 + 64'h2);
    rdn(0, OFS_RX_PU, 8, t0 + 64'h1);
    rdn(0, OFS_SYS_DIFF, 4, 64'h2);
    `CHK("sysdiff", 32'h0000_0002, sdiff)
    rdn(0, OFS_SYS_TIME, 8, t0 + 64'h3 + ofs + {32'h0, dly});
    // Host owns the loop; latch time compare 256 above
    @(posedge clk);
    hctrl <= 1'b1;
    latch <= lval;
    wrn(1, OFS_SYS_TIME, 4, {32'h0, lval + 32'h100});
    @(posedge clk);
    hend <= 1'b1;
    @(posedge clk);
    hend <= 1'b0;
    repeat (2) @(posedge clk);
    rdn(1, OFS_SYS_DIFF, 4, 64'h8000_000F);
    `CHK("sysdiff", 32'h8000_000F, sdiff)
    wrn(0, OFS_SYS_OFFSET, 1, 64'h77);
    rdn(1, OFS_SYS_OFFSET, 8, ofs);
    // Speed-counter restart lives outside this block
    acc(1, 1'b0, 1'b1, OFS_SYS_TIME, 8'h0);
    #1 ts = lt + ofs + {32'h0, dly};
    `CHK("systime", ts, stime)
    eq.push_back(ts[7:0]);
    idl();
    repeat (300) @(posedge clk);
    rdn(1, 16'h0911, 7, ts >> 8);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule : dct_receive_time_loop_bench
